// [hvsg_defines.vh]
// Constants for the high-voltage sense and GPIO interlock block
`ifndef HVSG_DEFINES_VH
`define HVSG_DEFINES_VH

`define HVSG_CLK_MHZ 10
`define HVSG_T_WAKE_US 16
`define HVSG_T_OC_US 26
`define HVSG_T_OL_US 64
`define HVSG_WAKE_CYC (`HVSG_T_WAKE_US * `HVSG_CLK_MHZ)
`define HVSG_OC_CYC (`HVSG_T_OC_US * `HVSG_CLK_MHZ)
`define HVSG_OL_CYC (`HVSG_T_OL_US * `HVSG_CLK_MHZ)

// Register indices (byte address = index)
`define HVSG_A_GPIO_CFG 4'h0
`define HVSG_A_MEAS 4'h1
`define HVSG_A_PULL 4'h2
`define HVSG_A_STATUS 4'h3
`define HVSG_A_MASK 4'h4
`define HVSG_A_WAKE_LOG 4'h5
`define HVSG_A_LEVEL 4'h6
`define HVSG_A_MODE 4'h7

// Pin configuration codes
`define HVSG_CFG_FO 3'h0
`define HVSG_CFG_HS_CS 3'h3
`define HVSG_CFG_OFF 3'h4
`define HVSG_CFG_WAKE 3'h5
`define HVSG_CFG_LS 3'h6
`define HVSG_CFG_HS 3'h7
`define HVSG_CFG_RST 3'h0

// Status bit positions
`define HVSG_ST_FAULT 0
`define HVSG_ST_WAKE 1
`define HVSG_ST_OC 2
`define HVSG_ST_OL 3
`define HVSG_ST_W 4

// Mode register: bit0 sleep request, bit1 GPIO wake only source
`define HVSG_MODE_SLEEP 0
`define HVSG_MODE_ONLY 1

`endif

// [hvsg_filter.v]
// Persistence filter: output follows input after it holds for CYC cycles
`timescale 1ns/1ps
`default_nettype none
module hvsg_filter #(
    parameter CYC = 16,
    parameter [0:0] INIT = 1'b0
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_b,
    input wire clk_en,
    // Filter
    input wire run,
    input wire raw,
    output reg qual_ff
);
    reg [9:0] cnt_ff;
    wire differs = (raw != qual_ff);
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_ff <= 10'h000;
            qual_ff <= INIT;
        end else if (clk_en) begin
            if (!run) begin
                // Idle filter forgets its verdict so a stale trip cannot
                // fire the moment the function is enabled again
                cnt_ff <= 10'h000;
                qual_ff <= INIT;
            end else if (!differs) begin
                cnt_ff <= 10'h000;
            end else if (cnt_ff == CYC[9:0] - 10'h001) begin
                cnt_ff <= 10'h000;
                qual_ff <= raw;
            end else begin
                cnt_ff <= cnt_ff + 10'h001;
            end
        end
    end
endmodule // hvsg_filter
`default_nettype wire

// [hvsg_pin_model.sv]
// Far-side pin model: wake source and switch load
`timescale 1ns/1ps
`default_nettype none
module hvsg_pin_model (
    // Switch drives
    input wire logic low_side_on_ff,
    input wire logic high_side_on_ff,
    // Load state set by the bench
    input wire logic shorted,
    input wire logic load_open,
    input wire logic wake_hi,
    // Comparators
    output logic overcurrent_raw,
    output logic open_load_raw,
    output logic wake_pin_level
);
    // A load fault only shows while a switch conducts
    assign overcurrent_raw = shorted & (low_side_on_ff | high_side_on_ff);
    assign open_load_raw = load_open & high_side_on_ff;
    assign wake_pin_level = wake_hi;
endmodule // hvsg_pin_model
`default_nettype wire

// [hvsg_top.v]
// Measurement-mode interlock, wake qualification and switch diagnosis
`timescale 1ns/1ps
`default_nettype none
`include "hvsg_defines.vh"
module hvsg_top (
    // Clock and reset
    input wire sys_clk,
    input wire rst_b,
    input wire clk_en,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_ff,
    // Pin sensing
    input wire wake_pin_level,
    input wire overcurrent_raw,
    input wire open_load_raw,
    input wire failure_event,
    // Pin control
    output reg meas_route_ff,
    output reg pull_up_en_ff,
    output reg pull_down_en_ff,
    output reg fail_out_drive_ff,
    output reg low_side_on_ff,
    output reg high_side_on_ff,
    output reg wake_signal_ff,
    output reg restart_req_ff,
    output reg irq_ff
);
    reg [2:0] gpio_cfg_ff;
    reg meas_ff;
    reg fo_test_ff;
    reg [1:0] pull_cfg_ff;
    reg [3:0] status_ff;
    reg [3:0] mask_ff;
    reg wake_log_ff;
    reg level_ff;
    reg [1:0] mode_ff;
    reg wake_q_d_ff;
    wire wake_q;
    wire oc_q;
    wire ol_q;

    wire wr_cfg = reg_wr && (reg_addr == `HVSG_A_GPIO_CFG);
    wire wr_meas = reg_wr && (reg_addr == `HVSG_A_MEAS);
    wire wr_pull = reg_wr && (reg_addr == `HVSG_A_PULL);
    wire wr_stat = reg_wr && (reg_addr == `HVSG_A_STATUS);
    wire wr_mask = reg_wr && (reg_addr == `HVSG_A_MASK);
    wire wr_log = reg_wr && (reg_addr == `HVSG_A_WAKE_LOG);
    wire wr_mode = reg_wr && (reg_addr == `HVSG_A_MODE);

    wire is_wake = (gpio_cfg_ff == `HVSG_CFG_WAKE);
    wire is_ls = (gpio_cfg_ff == `HVSG_CFG_LS);
    wire is_hs = (gpio_cfg_ff == `HVSG_CFG_HS) ||
        (gpio_cfg_ff == `HVSG_CFG_HS_CS);
    wire switch_on = (is_ls || is_hs) && !meas_ff;

    // Config write during measurement is refused in whole
    wire cfg_refuse = wr_cfg && meas_ff;
    // Fail-output test bit (bit 3) also counts as enabling fail output
    wire cfg_enables = (reg_wdata[2:0] != `HVSG_CFG_OFF) || reg_wdata[3];
    wire cfg_fault = cfg_refuse && cfg_enables;
    // Measurement may only be turned on when pin is Off
    wire meas_refuse = wr_meas && reg_wdata[0] && !meas_ff &&
        (gpio_cfg_ff != `HVSG_CFG_OFF);
    // Sleep with GPIO wake as the only source during measurement
    wire sleep_fault = wr_mode && reg_wdata[`HVSG_MODE_SLEEP] &&
        reg_wdata[`HVSG_MODE_ONLY] && meas_ff;

    // Filter runs only while wake monitoring is allowed
    wire wake_run = is_wake && !meas_ff;

    hvsg_filter #(.CYC(`HVSG_WAKE_CYC), .INIT(1'b0)) u_wake (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .run(wake_run),
        .raw(wake_pin_level),
        .qual_ff(wake_q)
    );

    hvsg_filter #(.CYC(`HVSG_OC_CYC), .INIT(1'b0)) u_oc (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .run(switch_on),
        .raw(overcurrent_raw),
        .qual_ff(oc_q)
    );

    hvsg_filter #(.CYC(`HVSG_OL_CYC), .INIT(1'b0)) u_ol (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .clk_en(clk_en),
        .run(is_hs && !meas_ff),
        .raw(open_load_raw),
        .qual_ff(ol_q)
    );

    wire wake_edge = wake_run && (wake_q != wake_q_d_ff);
    wire oc_trip = switch_on && oc_q;
    wire ol_trip = is_hs && !meas_ff && ol_q;

    // Events; set wins over write-one-to-clear
    reg [3:0] ev;
    reg [3:0] nxt_status;
    always @* begin
        ev = 4'h0;
        ev[`HVSG_ST_FAULT] = cfg_fault || meas_refuse || sleep_fault;
        ev[`HVSG_ST_WAKE] = wake_edge;
        ev[`HVSG_ST_OC] = oc_trip;
        ev[`HVSG_ST_OL] = ol_trip;
        nxt_status = status_ff;
        if (wr_stat) begin
            nxt_status = status_ff & ~reg_wdata[3:0];
        end
        nxt_status = nxt_status | ev;
    end

    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            gpio_cfg_ff <= `HVSG_CFG_RST;
            meas_ff <= 1'b0;
            fo_test_ff <= 1'b0;
            pull_cfg_ff <= 2'h0;
            status_ff <= 4'h0;
            mask_ff <= 4'h0;
            wake_log_ff <= 1'b0;
            level_ff <= 1'b0;
            mode_ff <= 2'h0;
            wake_q_d_ff <= 1'b0;
        end else if (clk_en) begin
            wake_q_d_ff <= wake_q;
            status_ff <= nxt_status;
            if (oc_trip) begin
                gpio_cfg_ff <= `HVSG_CFG_OFF;
            end else if (wr_cfg && !cfg_refuse) begin
                gpio_cfg_ff <= reg_wdata[2:0];
                fo_test_ff <= reg_wdata[3];
            end
            if (wr_meas && !meas_refuse) begin
                meas_ff <= reg_wdata[0];
            end
            if (wr_pull) begin
                pull_cfg_ff <= reg_wdata[1:0];
            end
            if (wr_mask) begin
                mask_ff <= reg_wdata[3:0];
            end
            if (wr_mode && !sleep_fault) begin
                mode_ff <= reg_wdata[1:0];
            end
            // Log and level hold while measuring
            if (wake_edge) begin
                wake_log_ff <= 1'b1;
            end else if (wr_log && reg_wdata[0]) begin
                wake_log_ff <= 1'b0;
            end
            if (wake_run) begin
                level_ff <= wake_q;
            end
        end
    end

    // Pin drive and routing
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            meas_route_ff <= 1'b0;
            pull_up_en_ff <= 1'b0;
            pull_down_en_ff <= 1'b0;
            fail_out_drive_ff <= 1'b0;
            low_side_on_ff <= 1'b0;
            high_side_on_ff <= 1'b0;
            wake_signal_ff <= 1'b0;
            restart_req_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else if (clk_en) begin
            meas_route_ff <= meas_ff;
            // Stored pull setting has no effect while measuring
            pull_up_en_ff <= !meas_ff && pull_cfg_ff[0];
            pull_down_en_ff <= !meas_ff && pull_cfg_ff[1];
            fail_out_drive_ff <= !meas_ff &&
                (gpio_cfg_ff == `HVSG_CFG_FO) &&
                (failure_event || fo_test_ff);
            low_side_on_ff <= switch_on && is_ls && !oc_trip;
            high_side_on_ff <= switch_on && is_hs && !oc_trip;
            wake_signal_ff <= wake_run && wake_q;
            restart_req_ff <= sleep_fault;
            irq_ff <= |(nxt_status & mask_ff);
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero
    always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_ff <= 8'h00;
        end else if (clk_en) begin
            reg_rdata_ff <= 8'h00;
            if (reg_rd) begin
                case (reg_addr)
                    `HVSG_A_GPIO_CFG: reg_rdata_ff <= {4'h0, fo_test_ff,
                        gpio_cfg_ff};
                    `HVSG_A_MEAS: reg_rdata_ff <= {7'h00, meas_ff};
                    `HVSG_A_PULL: reg_rdata_ff <= {6'h00, pull_cfg_ff};
                    `HVSG_A_STATUS: reg_rdata_ff <= {4'h0, status_ff};
                    `HVSG_A_MASK: reg_rdata_ff <= {4'h0, mask_ff};
                    `HVSG_A_WAKE_LOG: reg_rdata_ff <= {7'h00, wake_log_ff};
                    `HVSG_A_LEVEL: reg_rdata_ff <= {7'h00, level_ff};
                    `HVSG_A_MODE: reg_rdata_ff <= {6'h00, mode_ff};
                    default: reg_rdata_ff <= 8'h00;
                endcase
            end
        end
    end
endmodule // hvsg_top
`default_nettype wire

// [hvsg_top_chk.sv]
// Port assertions for the interlock block
`timescale 1ns/1ps
`default_nettype none
`include "hvsg_defines.vh"
module hvsg_top_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    // Register port
    input wire logic [3:0] reg_addr,
    input wire logic reg_wr,
    // Pin side
    input wire logic wake_pin_level,
    input wire logic overcurrent_raw,
    input wire logic meas_route_ff,
    input wire logic pull_up_en_ff,
    input wire logic pull_down_en_ff,
    input wire logic fail_out_drive_ff,
    input wire logic low_side_on_ff,
    input wire logic high_side_on_ff,
    input wire logic wake_signal_ff,
    input wire logic restart_req_ff
);
    int oc_cnt;
    int wk_cnt;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);
    // Run lengths of a held fault and of an unqualified wake level
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            oc_cnt <= 0;
            wk_cnt <= 0;
        end else if (clk_en) begin
            oc_cnt <= overcurrent_raw ? oc_cnt + 1 : 0;
            wk_cnt <= (wake_pin_level != wake_signal_ff) ? wk_cnt + 1 : 0;
        end
    end
    property p_pin_free; meas_route_ff |-> !fail_out_drive_ff
        && !low_side_on_ff && !high_side_on_ff; endproperty
    a_pin_free: assert property (p_pin_free)
        else $error("pin driven while measuring");
    property p_pulls; meas_route_ff |-> !pull_up_en_ff && !pull_down_en_ff;
    endproperty
    a_pulls: assert property (p_pulls)
        else $error("pull on while measuring");
    property p_gate; meas_route_ff |-> !wake_signal_ff; endproperty
    a_gate: assert property (p_gate)
        else $error("wake not gated");
    property p_route; $rose(meas_route_ff) |-> $past(reg_wr, 2)
        && $past(reg_addr, 2) == `HVSG_A_MEAS; endproperty
    a_route: assert property (p_route)
        else $error("route without write");
    property p_rst_pulse; restart_req_ff |=> !restart_req_ff; endproperty
    a_rst_pulse: assert property (p_rst_pulse)
        else $error("restart pulse too long");
    property p_oc_trip; oc_cnt > `HVSG_OC_CYC + 4 |-> !low_side_on_ff
        && !high_side_on_ff; endproperty
    a_oc_trip: assert property (p_oc_trip)
        else $error("switch kept on");
    property p_oc_early; $fell(low_side_on_ff) && $past(overcurrent_raw)
        |-> $past(oc_cnt) >= `HVSG_OC_CYC - 3; endproperty
    a_oc_early: assert property (p_oc_early)
        else $error("early trip");
    property p_wk_filt; $rose(wake_signal_ff)
        |-> $past(wk_cnt) >= `HVSG_WAKE_CYC - 3; endproperty
    a_wk_filt: assert property (p_wk_filt)
        else $error("wake unfiltered");
    c_route: cover property ($rose(meas_route_ff));
    c_restart: cover property (restart_req_ff);
    c_trip: cover property ($fell(low_side_on_ff));
endmodule // hvsg_top_chk
bind hvsg_top hvsg_top_chk u_chk (.*);
`default_nettype wire

// [tb_hv_sense_gpio_interlock.sv]
// Self-checking bench for the interlock block
`timescale 1ns/1ps
`default_nettype none
`include "hvsg_defines.vh"
module tb_hv_sense_gpio_interlock;
    logic sys_clk = 1'b0, rst_b = 1'b0, clk_en = 1'b1, seen;
    logic reg_wr = 1'b0, reg_rd = 1'b0, failure_event = 1'b0;
    logic shorted = 1'b0, load_open = 1'b0, wake_hi = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    wire [7:0] reg_rdata_ff;
    wire meas_route_ff, pull_up_en_ff, pull_down_en_ff, fail_out_drive_ff;
    wire low_side_on_ff, high_side_on_ff, wake_signal_ff, restart_req_ff;
    wire irq_ff, wake_pin_level, overcurrent_raw, open_load_raw;
    int failures = 0, checks_done = 0, cycles = 0;
    // Op nibble (1 read, 0 write), address nibble, data or expected
    logic [15:0] rows [16] = '{16'h1000, 16'h0101, 16'h1100, 16'h1301,
        16'h0301, 16'h1300, 16'h0004, 16'h0101, 16'h1101, 16'h0005,
        16'h1004, 16'h1301, 16'h0203, 16'h1203, 16'h1800, 16'h0800};
    hvsg_top dut (.*);
    hvsg_pin_model pins (.*);
    task automatic chk(input logic ok, input string m);
        checks_done++;
        if (!ok) begin
            failures++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata_ff === e, "read data");
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic complete_run();
        $display("Checks %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    // Cut a hang short well past the expected run length
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            complete_run();
        end
    end
    initial begin
        wait_cyc(12);
        chk(irq_ff === 1'b0 && meas_route_ff === 1'b0, "reset outputs");
        rst_b <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i][12])
                rd(rows[i][11:8], rows[i][7:0]);
            else
                wr(rows[i][11:8], rows[i][7:0]);
        end
        wait_cyc(3);
        chk(meas_route_ff === 1'b1, "no route");
        chk(pull_up_en_ff === 1'b0, "pull on");
        $display("Table test done");
        wake_hi <= 1'b1;
        wait_cyc(200);
        rd(`HVSG_A_WAKE_LOG, 8'h00);
        rd(`HVSG_A_LEVEL, 8'h00);
        wr(`HVSG_A_STATUS, 8'h1f);
        wr(`HVSG_A_MODE, 8'h03);
        seen = 1'b0;
        repeat (4) begin
            #1 seen = seen | (restart_req_ff === 1'b1);
            @(posedge sys_clk);
        end
        chk(seen, "no restart");
        rd(`HVSG_A_STATUS, 8'h01);
        wr(`HVSG_A_MODE, 8'h00);
        wake_hi <= 1'b0;
        $display("Measuring test done");
        wait_cyc(200);
        wr(`HVSG_A_MEAS, 8'h00);
        wr(`HVSG_A_STATUS, 8'h1f);
        wr(`HVSG_A_GPIO_CFG, {5'h00, `HVSG_CFG_WAKE});
        wr(`HVSG_A_MASK, 8'h02);
        wait_cyc(3);
        chk(pull_up_en_ff === 1'b1, "pull lost");
        wake_hi <= 1'b1;
        wait_cyc(100);
        rd(`HVSG_A_WAKE_LOG, 8'h00);
        wait_cyc(100);
        rd(`HVSG_A_WAKE_LOG, 8'h01);
        chk(irq_ff === 1'b1 && wake_signal_ff === 1'b1, "no wake");
        wr(`HVSG_A_STATUS, 8'h02);
        wait_cyc(3);
        chk(irq_ff === 1'b0, "irq stuck");
        $display("Wake test done");
        wr(`HVSG_A_GPIO_CFG, {5'h00, `HVSG_CFG_LS});
        wait_cyc(3);
        shorted <= 1'b1;
        wait_cyc(`HVSG_OC_CYC - 20);
        chk(low_side_on_ff === 1'b1, "early trip");
        wait_cyc(40);
        chk(low_side_on_ff === 1'b0, "no trip");
        rd(`HVSG_A_GPIO_CFG, {5'h00, `HVSG_CFG_OFF});
        shorted <= 1'b0;
        wr(`HVSG_A_GPIO_CFG, {5'h00, `HVSG_CFG_HS});
        load_open <= 1'b1;
        wait_cyc(`HVSG_OL_CYC - 20);
        rd(`HVSG_A_STATUS, 8'h04);
        wait_cyc(40);
        rd(`HVSG_A_STATUS, 8'h0c);
        wr(`HVSG_A_GPIO_CFG, 8'h00);
        failure_event <= 1'b1;
        wr(`HVSG_A_MEAS, 8'h01);
        rd(`HVSG_A_MEAS, 8'h00);
        chk(fail_out_drive_ff === 1'b1, "fail output idle");
        $display("Switch test done");
        complete_run();
    end
endmodule // tb_hv_sense_gpio_interlock
`default_nettype wire
